// ### dv/crs_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "crs_defines.svh"
module crs_sva (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// channels
	input wire logic cmp_a_debounce,
	input wire logic cmp_b_debounce,
	input wire logic [2:0] tmr_ovf,
	input wire logic cmp_a_sample_tick,
	input wire logic cmp_b_sample_tick,
	input wire logic [3:0] cmp_a_neg_route,
	input wire logic [3:0] cmp_b_neg_route
);
	logic [7:0] s_r;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) s_r <= 8'h00;
		else if (penable && pready && pwrite && paddr == `CRS_REF_CTRL_ADDR)
			s_r <= pwdata[7:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_a_route: assert property ($stable(s_r)[*3] |->
		cmp_a_neg_route == 4'h1 << s_r[1:0]) else $error("a route");
	chk_b_route: assert property ($stable(s_r)[*3] |->
		cmp_b_neg_route == 4'h1 << s_r[5:4]) else $error("b route");
	chk_a_sys_tick: assert property (
		(s_r[3:2] == 0 && !cmp_a_debounce)[*3] |-> cmp_a_sample_tick)
		else $error("a tick");
	chk_b_tmr_tick: assert property (
		($stable(s_r) && s_r[7:6] != 0 && !cmp_b_debounce)[*3] |->
		cmp_b_sample_tick == $past(tmr_ovf[s_r[7:6] - 1], 2))
		else $error("b tick");
	chk_a_debounce: assert property (cmp_a_debounce[*3] |->
		cmp_a_sample_tick == $past(tmr_ovf[1], 2)) else $error("a debounce");
endmodule : crs_sva
bind crs_top crs_sva chk_u (.*);
`default_nettype wire

// ### dv/crs_tmr_model.sv
`timescale 1ns/100ps
`default_nettype none
module crs_tmr_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// overflow pulses
	output logic [2:0] tmr_ovf
);
	logic [2:0] cnt_r;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) cnt_r <= 3'h0;
		else cnt_r <= cnt_r + 3'h1;
	// unlike phases so a wrong pick shows
	assign tmr_ovf = {cnt_r == 3'h7, cnt_r[1:0] == 2'h3, cnt_r[1:0] == 2'h1};
endmodule : crs_tmr_model
`default_nettype wire

// ### dv/crs_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "crs_defines.svh"
module crs_top_tb;
	localparam logic [11:0] RA = `CRS_REF_CTRL_ADDR;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic cmp_a_on = 0, cmp_b_on = 0, cmp_a_debounce = 0, cmp_b_debounce = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic pready, pslverr, err, cmp_a_sample_tick, cmp_b_sample_tick;
	logic neg_change_while_on;
	logic [2:0] tmr_ovf;
	logic [3:0] cmp_a_neg_route, cmp_b_neg_route;
	logic [2:0] ovf_d1 = 0, ovf_d2 = 0;
	int num_errors = 0, n_compared = 0;
	always #25 pclk = ~pclk;
	crs_tmr_model tm_u (.*);
	crs_top dut_u (.*);
	// overflow history, two edges back, as the ticks lag their cause
	always @(posedge pclk) begin
		ovf_d1 <= tmr_ovf;
		ovf_d2 <= ovf_d1;
	end
	task automatic chk(string nm, logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : xfer
	// index -1 means system clock, so the tick stands high
	task automatic tick_run(int ia, int ib);
		repeat (3) @(posedge pclk);
		repeat (8) begin
			@(posedge pclk);
			chk("tick a", cmp_a_sample_tick, ia < 0 ? 1'b1 : ovf_d2[ia]);
			chk("tick b", cmp_b_sample_tick, ib < 0 ? 1'b1 : ovf_d2[ib]);
		end
	endtask : tick_run
	task automatic stop_test;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	initial begin
		repeat (2000) @(posedge pclk);
		num_errors++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		xfer(0, RA, 0);
		chk("reset", q, 0);
		for (int c = 0; c < 4; c++) begin
			xfer(1, RA, 32'h55 * c);
			repeat (9) @(posedge pclk);
			chk("route", cmp_a_neg_route, 4'h1 << c);
			chk("route b", cmp_b_neg_route, 4'h1 << c);
			xfer(0, RA, 0);
			chk("read", q, 32'h55 * c);
		end
		tick_run(2, 2);
		cmp_a_debounce <= 1'b1;
		cmp_b_debounce <= 1'b1;
		tick_run(1, 1);
		cmp_a_debounce <= 1'b0;
		cmp_b_debounce <= 1'b0;
		xfer(1, RA, 32'h00);
		tick_run(-1, -1);
		xfer(1, RA, 32'h4C);
		tick_run(2, 0);
		xfer(1, RA, 32'h84);
		tick_run(0, 1);
		cmp_a_on <= 1'b1;
		xfer(1, RA, 32'h80);
		repeat (3) @(posedge pclk);
		chk("flag quiet", neg_change_while_on, 0);
		xfer(1, RA, 32'h01);
		repeat (3) @(posedge pclk);
		chk("flag set", neg_change_while_on, 1);
		cmp_a_on <= 1'b0;
		xfer(0, RA, 0);
		repeat (3) @(posedge pclk);
		chk("flag clear", neg_change_while_on, 0);
		cmp_b_on <= 1'b1;
		xfer(1, RA, 32'h11);
		repeat (3) @(posedge pclk);
		chk("flag b set", neg_change_while_on, 1);
		cmp_b_on <= 1'b0;
		xfer(0, RA, 0);
		chk("read b", q, 32'h11);
		repeat (3) @(posedge pclk);
		chk("flag b clear", neg_change_while_on, 0);
		xfer(1, 12'h000, 32'hFF);
		chk("slverr", err, 1);
		xfer(0, RA, 0);
		chk("ignored", q, 32'h11);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		xfer(0, RA, 0);
		chk("reset again", q, 0);
		chk("route reset", cmp_b_neg_route, 4'h1);
		stop_test();
	end
endmodule : crs_top_tb
`default_nettype wire

// ### hdl/crs_chan_if.sv
`timescale 1ns/100ps
`default_nettype none
interface crs_chan_if;
	crs_pkg::crs_clk_sel_t clk_sel;
	crs_pkg::crs_neg_sel_t neg_sel;
	logic debounce;
	logic [2:0] tmr_ovf;
	logic sample_tick;
	logic [3:0] neg_onehot;
	modport ctl (output clk_sel, output neg_sel, output debounce,
		output tmr_ovf, input sample_tick, input neg_onehot);
	modport sel (input clk_sel, input neg_sel, input debounce,
		input tmr_ovf, output sample_tick, output neg_onehot);
endinterface : crs_chan_if
`default_nettype wire

// ### hdl/crs_chan_sel.sv
`timescale 1ns/100ps
`default_nettype none
`include "crs_defines.svh"
module crs_chan_sel (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// channel settings and results
	crs_chan_if.sel ch
);
	logic tick_r;
	logic [3:0] neg_r;
	// debounce always samples on the timer 1 overflow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_r <= 1'b0;
		end else if (ch.debounce) begin
			tick_r <= ch.tmr_ovf[`CRS_DEBOUNCE_IDX]; // [RL1]
		end else begin
			case (ch.clk_sel) // [RL4] [RL5] [RL7]
				`CRS_CLK_SYS: tick_r <= 1'b1;
				`CRS_CLK_T0: tick_r <= ch.tmr_ovf[0];
				`CRS_CLK_T1: tick_r <= ch.tmr_ovf[1];
				`CRS_CLK_T2: tick_r <= ch.tmr_ovf[2];
				default: tick_r <= 1'b0;
			endcase
		end
	end
	// one-hot mux steering to the analog switch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			neg_r <= 4'h1;
		end else begin
			neg_r <= 4'h1 << ch.neg_sel; // [RL6] [RL7]
		end
	end
	assign ch.sample_tick = tick_r;
	assign ch.neg_onehot = neg_r;
endmodule : crs_chan_sel
`default_nettype wire

// ### hdl/crs_defines.svh
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH
// register map, byte address of the one register (word index 0xAF times four, so word aligned)
`define CRS_REF_CTRL_INDEX 8'hAF
`define CRS_REF_CTRL_ADDR 12'h2BC
`define CRS_REF_CTRL_RESET 8'h00
// field positions
`define CRS_A_NEG_LSB 0
`define CRS_A_CLK_LSB 2
`define CRS_B_NEG_LSB 4
`define CRS_B_CLK_LSB 6
// select codes
`define CRS_CLK_SYS 2'h0
`define CRS_CLK_T0 2'h1
`define CRS_CLK_T1 2'h2
`define CRS_CLK_T2 2'h3
`define CRS_NEG_PIN 2'h0
`define CRS_NEG_LOW 2'h1
`define CRS_NEG_NOM 2'h2
`define CRS_NEG_HIGH 2'h3
`define CRS_TIMER_DEBOUNCE 2'h2
// overflow bit that paces debounce sampling
`define CRS_DEBOUNCE_IDX 1
`endif

// ### hdl/crs_pkg.sv
package crs_pkg;
	typedef logic [1:0] crs_clk_sel_t;
	typedef logic [1:0] crs_neg_sel_t;
endpackage : crs_pkg

// ### hdl/crs_top.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "crs_defines.svh"
// Overview of operation
// (RL1) Debounced interrupt modes take their sampling tick from timer 1 overflow.
// (RL2) Software turns comparator B off before changing its negative input field.
// (RL3) Software turns comparator A off before changing its negative input field.
// (RL4) Comparator B has a two-bit clock select: system clock or timer 0/1/2 overflow.
// (RL5) Comparator A has the same two-bit clock select, code zero being system clock.
// (RL6) A two-bit field routes comparator B negative input to the pin or a reference.
// (RL7) Select codes run in binary order over the listed choices.
module crs_top (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// comparator state from the rest of the device
	input wire logic cmp_a_on,
	input wire logic cmp_b_on,
	input wire logic cmp_a_debounce,
	input wire logic cmp_b_debounce,
	// timer overflow pulses 0..2
	input wire logic [2:0] tmr_ovf,
	// to the comparator cores
	output logic cmp_a_sample_tick,
	output logic cmp_b_sample_tick,
	output logic [3:0] cmp_a_neg_route,
	output logic [3:0] cmp_b_neg_route,
	output logic neg_change_while_on
);
	logic [7:0] ctrl_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic viol_r;
	logic a_tick_r;
	logic b_tick_r;
	logic [3:0] a_route_r;
	logic [3:0] b_route_r;
	logic hit;
	logic wr;
	logic [7:0] wdata;
	assign hit = (paddr == `CRS_REF_CTRL_ADDR);
	// single-cycle access: pready rises the cycle after setup
	assign wr = psel && penable && pwrite && pready_r && hit;
	assign wdata = pwdata[7:0];
	crs_chan_if a_if ();
	crs_chan_if b_if ();
	assign a_if.clk_sel = ctrl_r[`CRS_A_CLK_LSB +: 2];
	assign a_if.neg_sel = ctrl_r[`CRS_A_NEG_LSB +: 2];
	assign a_if.debounce = cmp_a_debounce;
	assign a_if.tmr_ovf = tmr_ovf;
	assign b_if.clk_sel = ctrl_r[`CRS_B_CLK_LSB +: 2];
	assign b_if.neg_sel = ctrl_r[`CRS_B_NEG_LSB +: 2];
	assign b_if.debounce = cmp_b_debounce;
	assign b_if.tmr_ovf = tmr_ovf;
	crs_chan_sel u_a (.pclk(pclk), .presetn(presetn), .ch(a_if));
	crs_chan_sel u_b (.pclk(pclk), .presetn(presetn), .ch(b_if));
	// register write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `CRS_REF_CTRL_RESET;
		end else if (wr) begin
			ctrl_r <= wdata;
		end
	end
	// the write is still taken; a sticky flag tells software it erred
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			viol_r <= 1'b0;
		end else if (wr && ((cmp_a_on &&
				wdata[`CRS_A_NEG_LSB +: 2] != ctrl_r[`CRS_A_NEG_LSB +: 2]) ||
				(cmp_b_on &&
				wdata[`CRS_B_NEG_LSB +: 2] != ctrl_r[`CRS_B_NEG_LSB +: 2]))) begin
			viol_r <= 1'b1; // [RL2] [RL3]
		end else if (psel && penable && pready_r && !pwrite && hit) begin
			viol_r <= 1'b0;
		end
	end
	// apb handshake and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= psel && !penable;
			pslverr_r <= psel && !penable && !hit;
			if (psel && !penable && !pwrite && hit) begin
				prdata_r <= {24'h00_0000, ctrl_r};
			end else if (psel && !penable) begin
				prdata_r <= 32'h0000_0000;
			end
		end
	end
	// register the outputs of the selectors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_tick_r <= 1'b0;
			b_tick_r <= 1'b0;
			a_route_r <= 4'h1;
			b_route_r <= 4'h1;
		end else begin
			a_tick_r <= a_if.sample_tick;
			b_tick_r <= b_if.sample_tick;
			a_route_r <= a_if.neg_onehot;
			b_route_r <= b_if.neg_onehot;
		end
	end
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign neg_change_while_on = viol_r;
	assign cmp_a_sample_tick = a_tick_r;
	assign cmp_b_sample_tick = b_tick_r;
	assign cmp_a_neg_route = a_route_r;
	assign cmp_b_neg_route = b_route_r;
endmodule : crs_top
`default_nettype wire
